// ---- host_ctrl_model.sv ----
// Purpose: Host controller model that takes strobed characters.
// Assumes: Host data and error lines are valid while the strobe is high.
// Notes:   Captured words are {hard, test fault, parity, data}.

`timescale 1ns/1ps
`default_nettype none

module host_ctrl_model
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              strobe,
  input  wire logic [tape_check_pkg::DATA_W-1:0] data,
  input  wire logic                              parity,
  input  wire logic                              hard_err,
  input  wire logic                              test_fault
);
  logic [10:0] got_q[$];

  // The hard error level is only trusted with a strobe, so a sticky true
  // level shows up on every character of a corrected or failed record.
  always @(posedge clk)
  begin
    if (!rst && strobe)
      got_q.push_back({hard_err, test_fault, parity, data});
  end
endmodule : host_ctrl_model

`default_nettype wire

// ---- tape_check_pkg.sv ----
// Purpose: Shared constants for the tape read error check and correct block.
// Assumes: One system clock; a character time is a fixed count of cycles.
// Notes:   All counts below are in character times unless named _CYC.

package tape_check_pkg;

  // Cycles of CLK_SYS that make one character time.
  localparam int unsigned CHAR_CYC = 16;
  localparam int unsigned DIV_W    = 4;

  // Character-time windows of the read sequence.
  localparam int unsigned GAP_CHARS  = 22;
  localparam int unsigned LATE_CHARS = 22;
  localparam int unsigned POST_CHARS = 44;
  localparam int unsigned CNT_W      = 6;

  // Width of a character on tape, parity track excluded.
  localparam int unsigned DATA_W = 8;

  // Reset values.
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RST  = 6'h00;
  localparam logic [DIV_W-1:0]  DIV_RST  = 4'h0;

  typedef enum logic [0:0]
  {
    SEQ_RUN    = 1'b0,
    SEQ_SEARCH = 1'b1
  } seq_state_t;

endpackage : tape_check_pkg

// ---- tape_read_error_check_correct.sv ----
// Purpose: Parity check, format fault detection and single-track rebuild
//          on the read path of a phase-encoded tape formatter.
// Assumes: Sequence stage levels, strobes and sync-loss flags come from
//          logic on CLK_SYS; only the data envelope comes from a pin.
// Notes:   Character-time counts rest on a free-running divider.
// Operation
// RULE1: Odd parity over eight data tracks compared with the parity track.
// RULE2: Hard error pulses with the read strobe for a mismatched character.
// RULE3: Format fault drives hard error and forces the end search stage.
// RULE4: In end search, finish after 22 character times without track data.
// RULE5: Format fault flag sets when any of its four sources asserts.
// RULE6: Two or more tracks lost after lock-on release is a format fault.
// RULE7: Deskew storage overflow on any track is a format fault.
// RULE8: Ones test of the preamble while stage three set and four not.
// RULE9: Ones test of the postamble while stage five set and six not.
// RULE10: A one during either ones window asserts the stray one signal.
// RULE11: No first character within 22 character times of stage four: fault.
// RULE12: Gap must start within 44 character times of postamble start.
// RULE13: One track losing sync during a record sets correction mode.
// RULE14: In correction mode the rebuilt parity bit replaces the lost track.
// RULE15: Correction mode suppresses parity pulses and holds hard error.
// RULE16: Strobed parity fault also appears on a maintenance test output.
// RULE17: Read finish pulse lasts exactly one clock and ends the sequence.
// RULE18: From stage four, search for the all-ones end of preamble.
// RULE19: Read finish clears the format fault and correction mode.
// RULE20: Host samples hard error with each strobe; steady true is serious.

`timescale 1ns/1ps
`default_nettype none

module tape_read_error_check_correct
(
  input  wire logic                                 CLK_SYS,
  input  wire logic                                 RST,
  input  wire logic [tape_check_pkg::DATA_W-1:0]    TRACK_DATA,
  input  wire logic                                 PARITY_TRACK,
  input  wire logic                                 CHAR_VALID,
  input  wire logic                                 READ_STROBE,
  input  wire logic                                 DATA_PRESENT,
  input  wire logic                                 LOCK_ON_N,
  input  wire logic                                 MULTI_TRACK_SYNC_LOSS_N,
  input  wire logic                                 SINGLE_TRACK_SYNC_LOSS,
  input  wire logic [tape_check_pkg::DATA_W:0]      LOST_TRACK,
  input  wire logic                                 DESKEW_OVERFLOW_N,
  input  wire logic                                 SEQUENCE_STAGE_THREE,
  input  wire logic                                 SEQUENCE_STAGE_FOUR_ALT,
  input  wire logic                                 SEQUENCE_STAGE_FOUR,
  input  wire logic                                 SEQUENCE_STAGE_FIVE,
  input  wire logic                                 SEQUENCE_STAGE_SIX,
  input  wire logic                                 PREAMBLE_END_SEEN,
  input  wire logic                                 FIRST_CHAR_SENT,
  output logic [tape_check_pkg::DATA_W-1:0]         HOST_DATA,
  output logic                                      HOST_PARITY,
  output logic                                      HOST_READ_STROBE,
  output logic                                      HARD_ERROR_OUT,
  output logic                                      PARITY_MISMATCH,
  output logic                                      TEST_PARITY_FAULT,
  output logic                                      FORMAT_FAULT_FLAG,
  output logic                                      CORRECT_MODE,
  output logic                                      END_SEARCH_STAGE,
  output logic                                      READ_FINISH_PULSE,
  output logic                                      REBUILT_BIT_LINE,
  output logic                                      STRAY_ONE_SEEN_N,
  output logic                                      PREAMBLE_SEARCH
);

  localparam int unsigned DW = tape_check_pkg::DATA_W;
  localparam int unsigned CW = tape_check_pkg::CNT_W;
  localparam int unsigned VW = tape_check_pkg::DIV_W;

  localparam logic [VW-1:0] DIV_LAST =
    VW'(tape_check_pkg::CHAR_CYC - 1);
  localparam logic [CW-1:0] GAP_LAST =
    CW'(tape_check_pkg::GAP_CHARS - 1);
  localparam logic [CW-1:0] LATE_LAST =
    CW'(tape_check_pkg::LATE_CHARS - 1);
  localparam logic [CW-1:0] POST_LAST =
    CW'(tape_check_pkg::POST_CHARS - 1);

  ////////////////////////////////////////////////////////////////////////
  // Envelope synchroniser and character-time divider.

  logic          env_meta_q;
  logic          env_q;
  logic [VW-1:0] div_q;
  logic [VW-1:0] div_d;
  logic          tick;

  always_comb
  begin
    tick  = (div_q == DIV_LAST);
    div_d = tick ? tape_check_pkg::DIV_RST : div_q + VW'(1);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      env_meta_q <= 1'b0;
      env_q      <= 1'b0;
      div_q      <= tape_check_pkg::DIV_RST;
    end
    else
    begin
      env_meta_q <= DATA_PRESENT;
      env_q      <= env_meta_q;
      div_q      <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parity check and track rebuild.

  logic          corr_q;
  logic          corr_d;
  logic [DW:0]   raw_char;
  logic [DW:0]   fixed_char;
  logic          rebuilt;
  logic          mismatch;

  always_comb
  begin
    raw_char = {PARITY_TRACK, TRACK_DATA};
    // An even count of ones over all nine tracks breaks odd parity.
    mismatch = ~(^raw_char); // RULE1
    // The lost track is masked so the rebuilt bit restores odd parity.
    rebuilt  = ~(^(raw_char & ~LOST_TRACK));
    fixed_char = raw_char;
    if (corr_q)
    begin
      fixed_char = (raw_char & ~LOST_TRACK) |
                   (LOST_TRACK & {(DW+1){rebuilt}}); // RULE14
    end
  end

  assign PARITY_MISMATCH  = mismatch;
  assign REBUILT_BIT_LINE = corr_q & rebuilt; // RULE14

  ////////////////////////////////////////////////////////////////////////
  // Host output register and strobed parity pulse.

  logic [DW-1:0] hdata_q;
  logic [DW-1:0] hdata_d;
  logic          hpar_q;
  logic          hpar_d;
  logic          hstb_q;
  logic          perr_q;
  logic          perr_d;

  always_comb
  begin
    hdata_d = hdata_q;
    hpar_d  = hpar_q;
    if (READ_STROBE)
    begin
      hdata_d = fixed_char[DW-1:0];
      hpar_d  = fixed_char[DW];
    end
    // Correction mode already reports the record; single pulses are moot.
    perr_d = READ_STROBE & mismatch & ~corr_d; // RULE2 RULE15
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      hdata_q <= tape_check_pkg::DATA_RST;
      hpar_q  <= 1'b0;
      hstb_q  <= 1'b0;
      perr_q  <= 1'b0;
    end
    else
    begin
      hdata_q <= hdata_d;
      hpar_q  <= hpar_d;
      hstb_q  <= READ_STROBE;
      perr_q  <= perr_d;
    end
  end

  assign HOST_DATA         = hdata_q;
  assign HOST_PARITY       = hpar_q;
  assign HOST_READ_STROBE  = hstb_q;
  assign TEST_PARITY_FAULT = perr_q; // RULE16

  ////////////////////////////////////////////////////////////////////////
  // Ones test, late first character and postamble length.

  logic          ones_win;
  logic          stray;
  logic          first_q;
  logic          first_d;
  logic [CW-1:0] late_q;
  logic [CW-1:0] late_d;
  logic          late_hit;
  logic [CW-1:0] post_q;
  logic [CW-1:0] post_d;
  logic          post_end;
  logic          post_hit;

  always_comb
  begin
    ones_win = (SEQUENCE_STAGE_THREE & ~SEQUENCE_STAGE_FOUR_ALT) | // RULE8
               (SEQUENCE_STAGE_FIVE & ~SEQUENCE_STAGE_SIX);        // RULE9
    stray    = ones_win & CHAR_VALID & (|raw_char); // RULE10
    first_d  = SEQUENCE_STAGE_FOUR & (first_q | FIRST_CHAR_SENT);
    late_d   = late_q;
    late_hit = 1'b0;
    if (!SEQUENCE_STAGE_FOUR || first_d)
    begin
      late_d = tape_check_pkg::CNT_RST;
    end
    else if (tick)
    begin
      // The count rests on its last value so the fault fires again on every later tick.
      late_hit = (late_q == LATE_LAST); // RULE11
      if (!late_hit)
      begin
        late_d = late_q + CW'(1);
      end
    end
    post_d   = post_q;
    post_end = 1'b0;
    if (!SEQUENCE_STAGE_FIVE || END_SEARCH_STAGE)
    begin
      post_d = tape_check_pkg::CNT_RST;
    end
    else if (tick)
    begin
      post_end = (post_q == POST_LAST);
      post_d   = post_end ? post_q : post_q + CW'(1);
    end
    // Data still present here means the postamble was false.
    post_hit = post_end & env_q; // RULE12
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      first_q <= 1'b0;
      late_q  <= tape_check_pkg::CNT_RST;
      post_q  <= tape_check_pkg::CNT_RST;
    end
    else
    begin
      first_q <= first_d;
      late_q  <= late_d;
      post_q  <= post_d;
    end
  end

  assign STRAY_ONE_SEEN_N = ~stray; // RULE10
  assign PREAMBLE_SEARCH  =
    SEQUENCE_STAGE_FOUR & ~PREAMBLE_END_SEEN & ~first_q; // RULE18

  ////////////////////////////////////////////////////////////////////////
  // Format fault, correction mode and end-of-record search.

  tape_check_pkg::seq_state_t st_q;
  tape_check_pkg::seq_state_t st_d;
  logic          fault_q;
  logic          fault_d;
  logic [CW-1:0] gap_q;
  logic [CW-1:0] gap_d;
  logic          finish_d;
  logic          finish_q;
  logic          multi_src;
  logic          ovf_src;
  logic          any_src;

  always_comb
  begin
    multi_src = ~MULTI_TRACK_SYNC_LOSS_N & LOCK_ON_N; // RULE6
    ovf_src   = ~DESKEW_OVERFLOW_N | stray;           // RULE7 RULE10
    any_src   = multi_src | ovf_src | late_hit | post_hit; // RULE5
    st_d      = st_q;
    gap_d     = gap_q;
    finish_d  = 1'b0;
    case (st_q)
      tape_check_pkg::SEQ_RUN:
      begin
        gap_d = tape_check_pkg::CNT_RST;
        if (any_src || post_end)
        begin
          st_d = tape_check_pkg::SEQ_SEARCH; // RULE3
        end
      end
      tape_check_pkg::SEQ_SEARCH:
      begin
        // Any data restarts the quiet count; the gap must be unbroken.
        if (env_q)
        begin
          gap_d = tape_check_pkg::CNT_RST; // RULE4
        end
        else if (tick)
        begin
          if (gap_q == GAP_LAST)
          begin
            finish_d = 1'b1; // RULE4 RULE17
            gap_d    = tape_check_pkg::CNT_RST;
            // A source in the finish cycle opens a fresh search at once.
            st_d     = any_src ? tape_check_pkg::SEQ_SEARCH :
                                 tape_check_pkg::SEQ_RUN; // RULE3
          end
          else
          begin
            gap_d = gap_q + CW'(1);
          end
        end
      end
      default:
      begin
        st_d = tape_check_pkg::SEQ_RUN;
      end
    endcase
    // A new source in the finish cycle wins over the clear.
    fault_d = any_src | (fault_q & ~finish_d); // RULE5 RULE19
    corr_d = (SINGLE_TRACK_SYNC_LOSS & SEQUENCE_STAGE_FOUR) | // RULE13
             (corr_q & ~finish_d);                            // RULE19
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      st_q     <= tape_check_pkg::SEQ_RUN;
      fault_q  <= 1'b0;
      corr_q   <= 1'b0;
      gap_q    <= tape_check_pkg::CNT_RST;
      finish_q <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      fault_q  <= fault_d;
      corr_q   <= corr_d;
      gap_q    <= gap_d;
      finish_q <= finish_d;
    end
  end

  assign FORMAT_FAULT_FLAG = fault_q;
  assign CORRECT_MODE      = corr_q;
  assign END_SEARCH_STAGE  = (st_q == tape_check_pkg::SEQ_SEARCH);
  assign READ_FINISH_PULSE = finish_q;
  // The host sees faulty characters, faulty formats and rebuilt records.
  assign HARD_ERROR_OUT    = perr_q | fault_q | corr_q; // RULE2 RULE3 RULE15

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  sequence s_bad_strobe;
    READ_STROBE && PARITY_MISMATCH && !corr_d;
  endsequence

  sequence s_pulse_out;
    TEST_PARITY_FAULT && HARD_ERROR_OUT;
  endsequence

  par_pulse_a: assert property (s_bad_strobe |=> s_pulse_out ##1
    (!TEST_PARITY_FAULT || $past(READ_STROBE)))
    else $error("Parity pulse missing on strobe."); // RULE2

  parity_calc_a: assert property ((CHAR_VALID || READ_STROBE) |->
    (PARITY_MISMATCH == !(^{PARITY_TRACK, TRACK_DATA})))
    else $error("Odd character flagged."); // RULE1

  fault_hard_a: assert property ($rose(FORMAT_FAULT_FLAG) |->
    HARD_ERROR_OUT && END_SEARCH_STAGE)
    else $error("Format fault not acted on."); // RULE3

  src_set_a: assert property (any_src |=> FORMAT_FAULT_FLAG)
    else $error("Fault source lost."); // RULE5

  finish_once_a: assert property (READ_FINISH_PULSE |->
    $past(END_SEARCH_STAGE) ##1 !READ_FINISH_PULSE)
    else $error("Finish pulse not single."); // RULE17

  finish_gap_a: assert property (READ_FINISH_PULSE |->
    $past(gap_q) == GAP_LAST && !$past(env_q))
    else $error("Finish before quiet gap."); // RULE4

  corr_hold_a: assert property (CORRECT_MODE |->
    HARD_ERROR_OUT && !TEST_PARITY_FAULT)
    else $error("Correction mode output wrong."); // RULE15

  rebuild_odd_a: assert property (corr_q && READ_STROBE |=>
    ^{HOST_PARITY, HOST_DATA})
    else $error("Rebuilt character not odd."); // RULE14

  clear_fin_a: assert property (READ_FINISH_PULSE && !any_src &&
    !SINGLE_TRACK_SYNC_LOSS |=> !FORMAT_FAULT_FLAG && !CORRECT_MODE)
    else $error("Finish did not clear faults."); // RULE19

  late_char_a: assert property (late_hit |=> FORMAT_FAULT_FLAG)
    else $error("Late first character missed."); // RULE11

endmodule : tape_read_error_check_correct

`default_nettype wire

// ---- tape_read_error_check_correct_tb.sv ----
// Purpose: Self-checking bench for the tape read error check block.
// Assumes: The character tick runs free every CHAR_CYC cycles.
// Notes:   Control inputs travel in one vector, laid out below.

`timescale 1ns/1ps
`default_nettype none

module tape_read_error_check_correct_tb;
  localparam int C = tape_check_pkg::CHAR_CYC;
  // ctl: 0 lock_on_n, 1 multi_n, 2 single, 3 overflow_n, 4 stage3,
  // 5 stage4_alt, 6 stage4, 7 stage5, 8 stage6, 9 pre_end, 10 first,
  // 11 data_present, 12 char_valid.
  localparam logic [12:0] IDLE = 13'h000a;
  localparam logic [12:0] F_VAL [8] = '{13'h0002, 13'h0009, 13'h0008,
    13'h101a, 13'h108a, 13'h103a, 13'h004a, 13'h098a};
  localparam int F_LO [8] = '{1, 1, 0, 1, 1, 0, 21 * C, 43 * C};
  localparam int F_HI [8] = '{1, 1, 0, 1, 1, 0, 23 * C, 46 * C};
  logic        clk_sys, rst, read_strobe, par;
  logic [12:0] ctl;
  logic [7:0]  track, hdata;
  logic [8:0]  lost;
  logic        hpar, hstb, herr, pmis, tpf, fflag, cmode;
  logic        esearch, fin, rebuilt, stray_n, psearch;
  int          mismatches, tests_run, n;
  logic [10:0] exp_q[$];

  tape_read_error_check_correct dut
  (
    .CLK_SYS(clk_sys), .RST(rst), .TRACK_DATA(track), .PARITY_TRACK(par),
    .CHAR_VALID(ctl[12]), .READ_STROBE(read_strobe),
    .DATA_PRESENT(ctl[11]), .LOCK_ON_N(ctl[0]),
    .MULTI_TRACK_SYNC_LOSS_N(ctl[1]), .SINGLE_TRACK_SYNC_LOSS(ctl[2]),
    .LOST_TRACK(lost), .DESKEW_OVERFLOW_N(ctl[3]),
    .SEQUENCE_STAGE_THREE(ctl[4]), .SEQUENCE_STAGE_FOUR_ALT(ctl[5]),
    .SEQUENCE_STAGE_FOUR(ctl[6]), .SEQUENCE_STAGE_FIVE(ctl[7]),
    .SEQUENCE_STAGE_SIX(ctl[8]), .PREAMBLE_END_SEEN(ctl[9]),
    .FIRST_CHAR_SENT(ctl[10]), .HOST_DATA(hdata), .HOST_PARITY(hpar),
    .HOST_READ_STROBE(hstb), .HARD_ERROR_OUT(herr),
    .PARITY_MISMATCH(pmis), .TEST_PARITY_FAULT(tpf),
    .FORMAT_FAULT_FLAG(fflag), .CORRECT_MODE(cmode),
    .END_SEARCH_STAGE(esearch), .READ_FINISH_PULSE(fin),
    .REBUILT_BIT_LINE(rebuilt), .STRAY_ONE_SEEN_N(stray_n),
    .PREAMBLE_SEARCH(psearch)
  );

  host_ctrl_model host
  (
    .clk(clk_sys), .rst(rst), .strobe(hstb), .data(hdata), .parity(hpar),
    .hard_err(herr), .test_fault(tpf)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task report_and_stop;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Bounded wait on the fault flag (sel 0) or the finish pulse (sel 1).
  task automatic wait_sig(input int sel, input int lim);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while ((sel ? fin : fflag) !== 1'b1 && n < lim);
  endtask : wait_sig

  task automatic send(input logic [8:0] ch, input logic [10:0] exp,
                      input int k);
    @(posedge clk_sys);
    track <= ch[7:0];
    par <= ch[8];
    read_strobe <= 1'b1;
    exp_q.push_back(exp);
    #1;
    if (exp[10] == exp[9])
      chk(pmis, ~^ch);
    else
      chk(rebuilt, exp[k]);
  endtask : send

  task automatic drain(input int id);
    @(posedge clk_sys);
    read_strobe <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(host.got_q.size(), exp_q.size());
    while (exp_q.size() > 0 && host.got_q.size() > 0)
      chk(host.got_q.pop_front(), exp_q.pop_front());
    $display("strobe test %0d done", id);
  endtask : drain

  task automatic run_fault(input logic [12:0] val, input int lo, hi, id);
    @(posedge clk_sys);
    ctl <= val;
    track <= 8'h01 | 8'($urandom);
    wait_sig(0, (hi == 0) ? 20 : hi);
    chk({fflag, esearch, herr}, (hi == 0) ? 3'b000 : 3'b111);
    chk(hi == 0 || (n >= lo && n <= hi), 1);
    chk(stray_n, !(((val[4] && !val[5]) || (val[7] && !val[8])) && val[12]));
    @(posedge clk_sys);
    ctl <= IDLE;
    track <= 8'h00;
    if (hi != 0)
    begin
      // The quiet count only starts once the synchronised envelope drops.
      wait_sig(1, 23 * C + 8);
      chk(n >= 20 * C, 1);
      chk({fin, esearch, fflag, cmode, herr}, 5'b10000);
      @(posedge clk_sys);
      #1;
      chk(fin, 0);
    end
    $display("fault test %0d done", id);
  endtask : run_fault

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial
  begin
    #(20000 * 4);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    logic [8:0] ch, good;
    int         k;
    rst = 1'b1;
    ctl = IDLE;
    track = 8'h00;
    par = 1'b0;
    read_strobe = 1'b0;
    lost = 9'h000;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(10));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      ch = 9'($urandom);
      send(ch, {~^ch, ~^ch, ch}, 0);
    end
    drain(0);
    for (int i = 0; i < 8; i++)
      run_fault(F_VAL[i], F_LO[i], F_HI[i], i);
    k = $urandom_range(8, 0);
    @(posedge clk_sys);
    ctl <= 13'h004e;
    lost <= 9'h001 << k;
    #1;
    chk(psearch, 1);
    @(posedge clk_sys);
    ctl <= 13'h024a;
    #1;
    chk({cmode, herr, psearch}, 3'b110);
    for (int i = 0; i < 8; i++)
    begin
      good = 9'($urandom);
      good[8] = ~^good[7:0];
      ch = good ^ (9'($urandom) & (9'h001 << k));
      send(ch, {2'b10, good}, k);
    end
    drain(1);
    run_fault(13'h0002, 1, 1, 8);
    report_and_stop();
  end
endmodule : tape_read_error_check_correct_tb

`default_nettype wire
